//--- hw/reset_config_sequencer.sv
// reset and power-on configuration sequencer
// assumes open-drain reset lines with board pull-ups; all pins asynchronous to mclk_in
`timescale 1ns/1ps
`default_nettype none
module reset_config_sequencer
    import rst_seq_pkg::*;
#(
    parameter int PLL_WAIT_CYCLES = rst_seq_pkg::PLL_WAIT_CYC,
    parameter int DLL_MIN_CYCLES  = rst_seq_pkg::DLL_MIN_CYC,
    parameter int CYC_W           = 18
)
(
    // clock and reset
    input  wire logic                              mclk_in,
    input  wire logic                              rst_b_in,
    // power-on reset and clocking pins
    input  wire logic                              power_on_reset_b_in,
    input  wire logic                              pci_sync_in,
    input  wire logic                              pci_agent_mode_in,
    input  wire logic                              pll_locked_in,
    input  wire logic [1:0]                        dll_ratio_sel_in,
    // configuration straps
    input  wire logic [rst_seq_pkg::RST_SRC_W-1:0] reset_source_strap_in,
    input  wire logic                              input_clock_divide_strap_in,
    output logic [rst_seq_pkg::STRAP_W-1:0]        cfg_strap_out,
    output logic                                   cfg_strap_oe_out,
    // open-drain reset lines
    input  wire logic                              hard_reset_line_b_in,
    output logic                                   hard_reset_line_b_out,
    output logic                                   hard_reset_line_oe_out,
    input  wire logic                              soft_reset_line_b_in,
    output logic                                   soft_reset_line_b_out,
    output logic                                   soft_reset_line_oe_out,
    // captured configuration and status
    output logic [rst_seq_pkg::RST_SRC_W-1:0]      reset_source_out,
    output logic                                   input_clock_divide_out,
    output logic                                   agent_mode_out,
    output logic                                   seq_done_out
);
    import rst_seq_pkg::*;

    if (PLL_WAIT_CYCLES < 1 || PLL_WAIT_CYCLES >= 2**CYC_W || DLL_MIN_CYCLES < 1
        || DLL_MIN_CYCLES * DLL_MAX_SCALE >= 2**CYC_W)
    begin : g_bad_param
        $error("wait counts do not fit the cycle counter");
    end

    localparam logic [9:0] HOLD_T  = 10'(HOLD_TICKS);
    localparam logic [9:0] GAP_T   = 10'(SREL_GAP_TICKS);
    localparam logic [9:0] STRAP_T = 10'(STRAP_DRIVE_DELAY_TICKS);
    localparam logic [5:0] IN_T    = 6'(IN_ASSERT_TICKS);

    function automatic logic [CYC_W-1:0] dll_cycles(input logic [1:0] sel);
        logic [CYC_W-1:0] n;
        n = CYC_W'(DLL_MIN_CYCLES * DLL_MAX_SCALE);
        if (sel == RATIO_2TO1)
        begin
            n = CYC_W'(DLL_MIN_CYCLES);
        end
        else if (sel == RATIO_4TO1)
        begin
            n = CYC_W'(DLL_MIN_CYCLES * DLL_MID_SCALE);
        end
        return n;
    endfunction

    pci_tick_if tk ();

    logic [PIN_W-1:0]     pins;
    logic [PIN_W-1:0]     s1_q;
    logic [PIN_W-1:0]     s2_q;
    logic [PIN_W-1:0]     s3_q;
    logic [PIN_W-1:0]     filt_q;
    logic [PIN_W-1:0]     filt_d;
    seq_state_e           state_q;
    seq_state_e           state_d;
    logic [9:0]           tcnt_q;
    logic [9:0]           tcnt_d;
    logic [CYC_W-1:0]     ccnt_q;
    logic [CYC_W-1:0]     ccnt_d;
    logic [5:0]           hin_cnt_q;
    logic [5:0]           hin_cnt_d;
    logic [5:0]           sin_cnt_q;
    logic [5:0]           sin_cnt_d;
    logic                 hard_oe_q;
    logic                 hard_oe_d;
    logic                 soft_oe_q;
    logic                 soft_oe_d;
    logic                 strap_oe_q;
    logic                 strap_oe_d;
    logic [RST_SRC_W-1:0] src_q;
    logic [RST_SRC_W-1:0] src_d;
    logic                 div_q;
    logic                 div_d;
    logic                 agent_q;
    logic                 agent_d;
    logic                 done_q;
    logic                 done_d;
    logic                 por_ok;

    assign pins = {dll_ratio_sel_in, reset_source_strap_in, input_clock_divide_strap_in, pci_agent_mode_in,
                   pll_locked_in, soft_reset_line_b_in, hard_reset_line_b_in, power_on_reset_b_in};

    // bitwise: take the third stage once the second agrees with it
    assign filt_d = (~(s2_q ^ s3_q) & s3_q) | ((s2_q ^ s3_q) & filt_q);

    always_ff @(posedge mclk_in)
    begin
        if (!rst_b_in)
        begin
            s1_q   <= PIN_RST;
            s2_q   <= PIN_RST;
            s3_q   <= PIN_RST;
            filt_q <= PIN_RST;
        end
        else
        begin
            s1_q   <= pins;
            s2_q   <= s1_q;
            s3_q   <= s2_q;
            filt_q <= filt_d;
        end
    end

    assign tk.agent_mode = agent_q;
    assign tk.div_strap  = div_q;

    pci_tick_gen u_tick (
        .mclk_in     (mclk_in),
        .rst_b_in    (rst_b_in),
        .pci_sync_in (pci_sync_in),
        .tk          (tk.ticker)
    );

    assign por_ok = filt_q[P_POR];

    always_comb
    begin
        state_d    = state_q;
        tcnt_d     = tcnt_q;
        ccnt_d     = ccnt_q;
        hard_oe_d  = hard_oe_q;
        soft_oe_d  = soft_oe_q;
        strap_oe_d = strap_oe_q;
        src_d      = src_q;
        div_d      = div_q;
        agent_d    = agent_q;
        hin_cnt_d  = 6'h00;
        sin_cnt_d  = 6'h00;
        // keep tracking straps while power-on reset is low; last value stands at release
        if (!por_ok)
        begin
            src_d   = filt_q[P_SRC +: RST_SRC_W];
            div_d   = filt_q[P_DIV];
            agent_d = filt_q[P_AGENT];
        end
        // own drive reads back low, so the line is only watched while released
        if (!hard_oe_q && !filt_q[P_HIN])
        begin
            hin_cnt_d = (tk.tick && hin_cnt_q != IN_T) ? hin_cnt_q + 6'h01 : hin_cnt_q;
        end
        if (!soft_oe_q && !filt_q[P_SIN])
        begin
            sin_cnt_d = (tk.tick && sin_cnt_q != IN_T) ? sin_cnt_q + 6'h01 : sin_cnt_q;
        end
        unique case (state_q)
            ST_POR:
            begin
                if (por_ok)
                begin
                    state_d = ST_PLL;
                    ccnt_d  = '0;
                end
            end
            ST_PLL:
            begin
                if (filt_q[P_PLL] || ccnt_q == CYC_W'(PLL_WAIT_CYCLES - 1))
                begin
                    state_d = ST_DLL;
                    ccnt_d  = '0;
                end
                else
                begin
                    ccnt_d = ccnt_q + 1'b1;
                end
            end
            ST_DLL:
            begin
                // >= tolerates a ratio pin that moves mid-count
                if (ccnt_q >= dll_cycles(filt_q[P_RATIO +: 2]) - 1'b1)
                begin
                    state_d = ST_HOLD;
                    tcnt_d  = 10'h000;
                end
                else
                begin
                    ccnt_d = ccnt_q + 1'b1;
                end
            end
            ST_HOLD:
            begin
                // one extra tick: the first one may close a partial period
                if (tk.tick && tcnt_q == HOLD_T)
                begin
                    state_d   = ST_SGAP;
                    hard_oe_d = 1'b0;
                    tcnt_d    = 10'h000;
                end
                else if (tk.tick)
                begin
                    tcnt_d = tcnt_q + 10'h001;
                end
            end
            ST_SGAP:
            begin
                if (tk.tick && tcnt_q == STRAP_T)
                begin
                    strap_oe_d = 1'b1;
                end
                if (tk.tick && tcnt_q == GAP_T)
                begin
                    state_d   = ST_RUN;
                    soft_oe_d = 1'b0;
                    tcnt_d    = 10'h000;
                end
                else if (tk.tick)
                begin
                    tcnt_d = tcnt_q + 10'h001;
                end
            end
            ST_RUN:
            begin
            end
            ST_SOFT:
            begin
                if (tk.tick && tcnt_q == HOLD_T)
                begin
                    state_d   = ST_RUN;
                    soft_oe_d = 1'b0;
                    tcnt_d    = 10'h000;
                end
                else if (tk.tick)
                begin
                    tcnt_d = tcnt_q + 10'h001;
                end
            end
        endcase
        // restarts: power-on over hard line over soft line
        if (hin_cnt_q == IN_T)
        begin
            state_d    = ST_HOLD;
            hard_oe_d  = 1'b1;
            soft_oe_d  = 1'b1;
            strap_oe_d = 1'b0;
            tcnt_d     = 10'h000;
            hin_cnt_d  = 6'h00;
        end
        else if (sin_cnt_q == IN_T && state_q == ST_RUN)
        begin
            state_d   = ST_SOFT;
            soft_oe_d = 1'b1;
            tcnt_d    = 10'h000;
            sin_cnt_d = 6'h00;
        end
        if (!por_ok)
        begin
            state_d    = ST_POR;
            hard_oe_d  = 1'b1;
            soft_oe_d  = 1'b1;
            strap_oe_d = 1'b0;
            tcnt_d     = 10'h000;
            ccnt_d     = '0;
        end
        done_d = (state_d == ST_RUN);
    end

    always_ff @(posedge mclk_in)
    begin
        if (!rst_b_in)
        begin
            state_q    <= ST_POR;
            tcnt_q     <= 10'h000;
            ccnt_q     <= '0;
            hin_cnt_q  <= 6'h00;
            sin_cnt_q  <= 6'h00;
            hard_oe_q  <= 1'b1;
            soft_oe_q  <= 1'b1;
            strap_oe_q <= 1'b0;
            src_q      <= SRC_RST;
            div_q      <= 1'b0;
            agent_q    <= 1'b0;
            done_q     <= 1'b0;
        end
        else
        begin
            state_q    <= state_d;
            tcnt_q     <= tcnt_d;
            ccnt_q     <= ccnt_d;
            hin_cnt_q  <= hin_cnt_d;
            sin_cnt_q  <= sin_cnt_d;
            hard_oe_q  <= hard_oe_d;
            soft_oe_q  <= soft_oe_d;
            strap_oe_q <= strap_oe_d;
            src_q      <= src_d;
            div_q      <= div_d;
            agent_q    <= agent_d;
            done_q     <= done_d;
        end
    end

    // open drain: the level is always low, only the enable moves
    assign hard_reset_line_b_out  = 1'b0;
    assign soft_reset_line_b_out  = 1'b0;
    assign hard_reset_line_oe_out = hard_oe_q;
    assign soft_reset_line_oe_out = soft_oe_q;
    assign cfg_strap_out          = {src_q, div_q};
    assign cfg_strap_oe_out       = strap_oe_q;
    assign reset_source_out       = src_q;
    assign input_clock_divide_out = div_q;
    assign agent_mode_out         = agent_q;
    assign seq_done_out           = done_q;

    // tick counters seen only by the checks below
    logic [10:0] hold_ticks_q;
    logic [10:0] gap_ticks_q;

    always_ff @(posedge mclk_in)
    begin
        if (!rst_b_in)
        begin
            hold_ticks_q <= 11'h000;
            gap_ticks_q  <= 11'h000;
        end
        else
        begin
            hold_ticks_q <= !hard_oe_q ? 11'h000 : hold_ticks_q + {10'h000, tk.tick && hold_ticks_q != 11'h7FF};
            gap_ticks_q  <= hard_oe_q ? 11'h000 : gap_ticks_q + {10'h000, tk.tick && gap_ticks_q != 11'h7FF};
        end
    end

    default clocking cb @(posedge mclk_in); endclocking
    default disable iff (!rst_b_in);

    sequence seq_dll_done;
        (state_q == ST_DLL) ##1 (state_q == ST_HOLD);
    endsequence
    a_hold_min_ticks: assert property ($fell(hard_oe_q) |-> hold_ticks_q >= 11'(HOLD_TICKS))
        else $error("hard reset released before its minimum hold");
    a_soft_gap_ticks: assert property ($fell(soft_oe_q) |-> !hard_oe_q && gap_ticks_q >= 11'(SREL_GAP_TICKS))
        else $error("soft reset released too soon after hard reset");
    a_soft_covers_hard: assert property (hard_oe_q |-> soft_oe_q)
        else $error("hard reset driven without soft reset");
    a_strap_drive_delay: assert property ($rose(strap_oe_q) |-> !hard_oe_q && gap_ticks_q > {1'b0, STRAP_T})
        else $error("straps driven too early after hard release");
    a_strap_vs_hard: assert property (!(hard_oe_q && strap_oe_q))
        else $error("straps driven during hard reset");
    a_strap_frozen: assert property (por_ok && $past(por_ok) |-> $stable(src_q) && $stable(div_q))
        else $error("straps changed after power-on release");
    a_pll_wait_bound: assert property (state_q == ST_PLL |-> ccnt_q < CYC_W'(PLL_WAIT_CYCLES))
        else $error("pll wait overran its bound");
    a_dll_wait_len: assert property (seq_dll_done |->
        $past(ccnt_q) + 1'b1 >= dll_cycles($past(filt_q[P_RATIO +: 2])))
        else $error("dll wait cut short");
    a_hard_restart_len: assert property ($rose(hard_oe_q) && $past(por_ok) |-> $past(hin_cnt_q) == IN_T)
        else $error("hard restart without full input assertion");
endmodule
`default_nettype wire

//--- hw/rst_seq_pkg.sv
// constants, pin positions and state type for the reset sequencer
// assumes a single 100 MHz sequencer clock; pins arrive asynchronously
package rst_seq_pkg;

    // sequencer clock and long waits
    localparam int CLK_PERIOD_NS = 10;
    localparam int PLL_WAIT_US   = 100;
    localparam int PLL_WAIT_CYC  = (PLL_WAIT_US * 1000) / CLK_PERIOD_NS;
    localparam int DLL_MIN_CYC   = 7680;
    localparam int DLL_MAX_CYC   = 122880;
    localparam int DLL_MAX_SCALE = DLL_MAX_CYC / DLL_MIN_CYC;
    // geometric middle between 2:1 and 8:1
    localparam int DLL_MID_SCALE = 4;

    // timing in pci sync periods
    localparam int HOLD_TICKS              = 512;
    localparam int SREL_GAP_TICKS          = 16;
    localparam int IN_ASSERT_TICKS         = 32;
    localparam int STRAP_DRIVE_DELAY_TICKS = 1;

    // host mode divide of the primary clock, by divide strap
    localparam logic [1:0] HOST_DIV_LO = 2'h1;
    localparam logic [1:0] HOST_DIV_HI = 2'h2;

    // output to bus clock ratio select
    localparam logic [1:0] RATIO_2TO1 = 2'h0;
    localparam logic [1:0] RATIO_4TO1 = 2'h1;

    // strap field widths
    localparam int RST_SRC_W = 3;
    localparam int STRAP_W   = RST_SRC_W + 1;

    // positions in the synchronised pin vector
    localparam int P_POR   = 0;
    localparam int P_HIN   = 1;
    localparam int P_SIN   = 2;
    localparam int P_PLL   = 3;
    localparam int P_AGENT = 4;
    localparam int P_DIV   = 5;
    localparam int P_SRC   = 6;
    localparam int P_RATIO = 9;
    localparam int PIN_W   = 11;
    localparam logic [PIN_W-1:0] PIN_RST = 11'h006;

    // reset values of captured straps
    localparam logic [RST_SRC_W-1:0] SRC_RST = 3'h0;

    typedef enum logic [2:0] {ST_POR, ST_PLL, ST_DLL, ST_HOLD, ST_SGAP, ST_RUN, ST_SOFT} seq_state_e;

endpackage

//--- hw/pci_tick_if.sv
// carries the pci sync period tick between the sequencer and its tick source
// assumes both ends run on mclk_in
`timescale 1ns/1ps
`default_nettype none
interface pci_tick_if;
    logic agent_mode;
    logic div_strap;
    logic tick;

    modport ticker   (input agent_mode, input div_strap, output tick);
    modport consumer (output agent_mode, output div_strap, input tick);
endinterface
`default_nettype wire

//--- hw/pci_tick_gen.sv
// one-cycle enable per pci sync period
// host mode: divided from mclk_in; agent mode: rising edges of the pci sync pin
`timescale 1ns/1ps
`default_nettype none
module pci_tick_gen
    import rst_seq_pkg::*;
(
    // clock and reset
    input  wire logic    mclk_in,
    input  wire logic    rst_b_in,
    // agent mode clock pin
    input  wire logic    pci_sync_in,
    // tick to the sequencer
    pci_tick_if.ticker   tk
);
    logic [2:0] sync_q;
    logic [2:0] sync_d;
    logic       filt_q;
    logic       filt_d;
    logic [1:0] div_q;
    logic [1:0] div_d;
    logic       tick_q;
    logic       tick_d;
    logic [1:0] lim;

    always_comb
    begin
        sync_d = {sync_q[1:0], pci_sync_in};
        // only the second and third stage agree on a level
        filt_d = (sync_q[1] == sync_q[2]) ? sync_q[2] : filt_q;
        lim    = tk.div_strap ? HOST_DIV_HI : HOST_DIV_LO;
        if (div_q >= lim - 2'h1)
        begin
            div_d = 2'h0;
        end
        else
        begin
            div_d = div_q + 2'h1;
        end
        if (tk.agent_mode)
        begin
            tick_d = filt_d & ~filt_q;
        end
        else
        begin
            tick_d = (div_q >= lim - 2'h1);
        end
    end

    always_ff @(posedge mclk_in)
    begin
        if (!rst_b_in)
        begin
            sync_q <= 3'h0;
            filt_q <= 1'b0;
            div_q  <= 2'h0;
            tick_q <= 1'b0;
        end
        else
        begin
            sync_q <= sync_d;
            filt_q <= filt_d;
            div_q  <= div_d;
            tick_q <= tick_d;
        end
    end

    assign tk.tick = tick_q;

    default clocking cb @(posedge mclk_in); endclocking
    default disable iff (!rst_b_in);

    a_host_div_two: assert property ((!tk.agent_mode && tk.div_strap && $past(tk.div_strap) && tick_q)
        |=> !tick_q)
        else $error("host divide by two ticked twice in a row");
endmodule
`default_nettype wire

//--- verif/board_reset_model.sv
// board side of the reset sequencer: por driver, strap drivers, line pull-ups
// assumes the bench commands it at the falling edge of mclk_in
`timescale 1ns/1ps
`default_nettype none
module board_reset_model
    import rst_seq_pkg::*;
#(
    parameter int SYNC_HALF_NS = 40
)
(
    // commands from the bench
    input  wire logic                              mclk_in,
    input  wire logic                              por_hold_in,
    input  wire logic                              hard_pull_in,
    input  wire logic                              soft_pull_in,
    input  wire logic                              lock_in,
    input  wire logic [rst_seq_pkg::RST_SRC_W-1:0] src_in,
    input  wire logic                              div_in,
    // device side
    input  wire logic                              hard_oe_in,
    input  wire logic                              soft_oe_in,
    input  wire logic                              strap_oe_in,
    input  wire logic [rst_seq_pkg::STRAP_W-1:0]   cfg_strap_in,
    // pins
    output logic                                   por_b_out,
    output logic                                   pci_sync_out,
    output logic                                   hard_line_b_out,
    output logic                                   soft_line_b_out,
    output logic [rst_seq_pkg::RST_SRC_W-1:0]      src_strap_out,
    output logic                                   div_strap_out,
    output logic                                   pll_locked_out
);
    import rst_seq_pkg::*;

    // free-running sync clock, odd start phase against mclk_in
    initial
    begin
        pci_sync_out = 1'b0;
        #3;
        forever #(SYNC_HALF_NS) pci_sync_out = ~pci_sync_out;
    end

    // bench keeps por low for at least 40 periods
    assign por_b_out       = !por_hold_in;
    // open drain with pull-up: low if either party pulls
    assign hard_line_b_out = !(hard_oe_in | hard_pull_in);
    assign soft_line_b_out = !(soft_oe_in | soft_pull_in);
    assign pll_locked_out  = lock_in & !por_hold_in;

    // straps held until hard release; released pins wander, never keep a value
    initial {src_strap_out, div_strap_out} = 4'h0;
    always @(negedge mclk_in)
    begin
        if (strap_oe_in)
            {src_strap_out, div_strap_out} <= cfg_strap_in;
        else if (!hard_line_b_out)
            {src_strap_out, div_strap_out} <= {src_in, div_in};
        else
            {src_strap_out, div_strap_out} <= ~{src_strap_out, div_strap_out};
    end
endmodule
`default_nettype wire

//--- verif/test_reset_config_sequencer.sv
// self-checking bench for the reset sequencer
// assumes short pll/dll waits by parameter; board model drives all pins except agent mode and ratio select, which the bench drives
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, exp, got) begin num_checks++; if ((got) !== (exp)) begin errors++; \
    $display("mismatch %s expected %0h seen %0h", nm, (exp), (got)); end end
module test_reset_config_sequencer;
    import rst_seq_pkg::*;
    localparam int PLL_W = 20;
    localparam int DLL_M = 8;
    localparam int SYNC_CYC = 8;

    logic                 mclk, rst_b, agent, por_hold, hard_pull, soft_pull, lock, div;
    logic [1:0]           ratio;
    logic [RST_SRC_W-1:0] src;
    wire logic            por_b, pci_sync, hard_b, soft_b, pll_locked, div_pin;
    wire logic            strap_oe, hard_oe, soft_oe, cdiv, amode, done, hard_drv, soft_drv;
    wire logic [RST_SRC_W-1:0] src_pin, rs_out;
    wire logic [STRAP_W-1:0]   cfg;
    int                   errors, num_checks;
    logic [31:0]          seed;

    initial mclk = 1'b0;
    always #5 mclk = ~mclk;

    board_reset_model #(.SYNC_HALF_NS(SYNC_CYC * 5)) model_u (
        .mclk_in(mclk), .por_hold_in(por_hold), .hard_pull_in(hard_pull), .soft_pull_in(soft_pull),
        .lock_in(lock), .src_in(src), .div_in(div), .hard_oe_in(hard_oe), .soft_oe_in(soft_oe),
        .strap_oe_in(strap_oe), .cfg_strap_in(cfg), .por_b_out(por_b), .pci_sync_out(pci_sync),
        .hard_line_b_out(hard_b), .soft_line_b_out(soft_b), .src_strap_out(src_pin),
        .div_strap_out(div_pin), .pll_locked_out(pll_locked));

    reset_config_sequencer #(.PLL_WAIT_CYCLES(PLL_W), .DLL_MIN_CYCLES(DLL_M), .CYC_W(18)) dut_u (
        .mclk_in(mclk), .rst_b_in(rst_b), .power_on_reset_b_in(por_b), .pci_sync_in(pci_sync),
        .pci_agent_mode_in(agent), .pll_locked_in(pll_locked), .dll_ratio_sel_in(ratio),
        .reset_source_strap_in(src_pin), .input_clock_divide_strap_in(div_pin), .cfg_strap_out(cfg),
        .cfg_strap_oe_out(strap_oe), .hard_reset_line_b_in(hard_b), .hard_reset_line_b_out(hard_drv),
        .hard_reset_line_oe_out(hard_oe), .soft_reset_line_b_in(soft_b), .soft_reset_line_b_out(soft_drv),
        .soft_reset_line_oe_out(soft_oe), .reset_source_out(rs_out), .input_clock_divide_out(cdiv),
        .agent_mode_out(amode), .seq_done_out(done));

    function automatic logic [31:0] rnd();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction

    // mclk cycles per sync period
    function automatic int tick_cyc(input logic a, input logic d);
        return a ? SYNC_CYC : (d ? 2 : 1);
    endfunction

    function automatic int dll_cyc(input logic [1:0] r);
        return (r == 2'h0) ? DLL_M : ((r == 2'h1) ? DLL_M * 4 : DLL_M * 16);
    endfunction

    function automatic logic sig(input int sel);
        return (sel == 0) ? hard_oe : ((sel == 1) ? soft_oe : strap_oe);
    endfunction

    task automatic summarize();
        $display("checks %0d mismatches %0d", num_checks, errors);
        if (errors == 0 && num_checks > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask

    // counts falling edges until the selected output reaches v
    task automatic wait_for(input int sel, input logic v, input int bound, output int n);
        n = 0;
        while (sig(sel) !== v && n < bound)
        begin
            @(negedge mclk);
            n++;
        end
        if (n >= bound)
        begin
            errors++;
            $display("mismatch wait_%0d expected %0h seen timeout", sel, v);
            summarize();
        end
    endtask

    task automatic run_por(input logic a, input logic d, input logic [1:0] r, input logic [2:0] s);
        int tc;
        int n1;
        int n2;
        int n3;
        tc = tick_cyc(a, d);
        agent = a;
        div = d;
        src = s;
        ratio = r;
        lock = 1'(rnd());
        por_hold = 1'b1;
        // straps settle long before por release
        repeat (40 * tc) @(negedge mclk);
        `CHK("hard_oe_por", 1'b1, hard_oe)
        `CHK("strap_oe_por", 1'b0, strap_oe)
        por_hold = 1'b0;
        wait_for(0, 1'b0, 40000, n1);
        `CHK("hard_hold_min", 1'b1, n1 >= dll_cyc(r) + 512 * tc)
        `CHK("hard_hold_max", 1'b1, n1 <= PLL_W + dll_cyc(r) + 515 * tc + 12)
        `CHK("src_captured", s, rs_out)
        `CHK("div_captured", d, cdiv)
        `CHK("agent_captured", a, amode)
        `CHK("soft_oe_held", 1'b1, soft_oe)
        `CHK("line_drive_low", 2'h0, {hard_drv, soft_drv})
        wait_for(2, 1'b1, 100 * tc, n2);
        `CHK("strap_on_min", 1'b1, n2 >= tc)
        `CHK("strap_on_max", 1'b1, n2 <= 3 * tc + 8)
        `CHK("strap_value", {s, d}, cfg)
        wait_for(1, 1'b0, 100 * tc, n3);
        `CHK("soft_gap_min", 1'b1, n2 + n3 >= 16 * tc)
        `CHK("soft_gap_max", 1'b1, n2 + n3 <= 18 * tc + 8)
        @(negedge mclk);
        `CHK("seq_done", 1'b1, done)
        $display("test por agent %0d div %0d ratio %0d done", a, d, r);
    endtask

    initial
    begin
        int n;
        logic [2:0] cfg_tbl [6];
        errors = 0;
        num_checks = 0;
        seed = 32'd99;
        rst_b = 1'b0;
        {agent, div, ratio, src, lock} = 8'h0;
        {por_hold, hard_pull, soft_pull} = 3'h4;
        // host, divided at 8:1, agent, divided at 4:1, then random, last host undivided
        cfg_tbl = '{3'h0, 3'h3, 3'h4, 3'h2, 3'h0, 3'h0};
        repeat (5) @(negedge mclk);
        rst_b = 1'b1;
        for (int i = 0; i < 6; i++)
        begin
            if (i == 4)
                run_por(1'(rnd()), 1'(rnd()), 2'(rnd()), 3'(rnd()));
            else
                run_por(cfg_tbl[i][2], cfg_tbl[i][1], {cfg_tbl[i][0], i == 3}, 3'(rnd()));
        end
        // short hard pull must not restart
        hard_pull = 1'b1;
        repeat (28) @(negedge mclk);
        hard_pull = 1'b0;
        repeat (10) @(negedge mclk);
        `CHK("short_pull_ignored", 1'b0, hard_oe)
        hard_pull = 1'b1;
        wait_for(0, 1'b1, 60, n);
        hard_pull = 1'b0;
        `CHK("hard_pull_min", 1'b1, n >= 31)
        repeat (2) @(negedge mclk);
        `CHK("strap_off_restart", 1'b0, strap_oe)
        wait_for(0, 1'b0, 700, n);
        `CHK("restart_hold", 1'b1, n >= 510 && n <= 530)
        `CHK("src_kept", src, rs_out)
        wait_for(1, 1'b0, 60, n);
        $display("test hard line restart done");
        // soft pull in run state restarts soft only
        repeat (5) @(negedge mclk);
        soft_pull = 1'b1;
        wait_for(1, 1'b1, 60, n);
        soft_pull = 1'b0;
        `CHK("soft_pull_min", 1'b1, n >= 31)
        `CHK("hard_untouched", 1'b0, hard_oe)
        wait_for(1, 1'b0, 700, n);
        `CHK("soft_hold", 1'b1, n >= 510)
        `CHK("straps_kept", 1'b1, strap_oe)
        $display("test soft line restart done");
        summarize();
    end
endmodule
`default_nettype wire
